/* motion_command_interpreter.sv */
// Behaviour
// - Code 1: velocity mode, positive target velocity
// - Code 2: velocity mode, negated target velocity
// - Velocity argument counted in microsteps per second
// - Code 3: velocity mode, target velocity zero
// - Code 4: position mode, write target position
// - Relative move adds offset to actual position
// - Move replies at once, no arrival wait
// - Stop or rotate abandons running move
// - Direction from wrapping 32-bit position difference
// - Position arguments are signed 32-bit
// - Code 5 writes value to typed parameter
// - Parameters held in volatile flops only
// - Code 6 returns selected parameter value
// - Direct mode leaves accumulator untouched
// - Request is nine bytes, value MSB first
// - Checksum is byte sum modulo 256
// - Reply nine bytes, reply address first
// - Failures report status codes 1,2,3,6
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_cfg.svh"
module motion_command_interpreter (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        rxValid,
  input  wire logic [7:0]                  rxData,
  input  wire logic                        standaloneMode,
  input  wire logic signed [31:0]          actualPos,
  output var  logic                        txValid,
  output var  logic [7:0]                  txData,
  output var  logic                        replyBusy,
  output var  motion_cmd_pkg::motion_mode_t mode,
  output var  logic signed [31:0]          targetVel,
  output var  logic signed [31:0]          targetPos,
  output var  logic                        moveDirNeg,
  output var  logic signed [31:0]          accumulator
);
  import motion_cmd_pkg::*;

  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00,
    ST_EXEC    = 2'b01,
    ST_REPLY   = 2'b10,
    ST_WAIT    = 2'b11
  } phase_t;

  phase_t      phase;        // Interpreter phase
  request_t    req;          // Captured request
  logic [3:0]  byteIdx;      // Incoming byte count
  logic [7:0]  rxSum;        // Running checksum of request
  logic [7:0]  sumCheck;     // Sum of bytes 0..7
  reply_t      rep;          // Reply being built
  logic        repStart;     // Kick serializer
  logic        serBusy;      // Serializer running
  logic signed [31:0] params [`AP_COUNT]; // Volatile axis parameter store
  logic [`AP_IDX_W-1:0] pIdx;             // Selected parameter
  logic        pValid;                    // Parameter number in range
  logic signed [31:0] posDiff;            // Target minus actual
  logic signed [31:0] readVal;            // Value returned by a parameter read

  assign pIdx   = req.kind[`AP_IDX_W-1:0];
  assign pValid = (req.kind < 8'(`AP_COUNT));
  assign posDiff = targetPos - actualPos;

  // Read value; live registers shadow the store for parameters 0..2
  always_comb begin
    if (req.kind == `AP_ACTUAL_POS) readVal = actualPos;
    else if (req.kind == `AP_TARGET_POS) readVal = targetPos;
    else if (req.kind == `AP_TARGET_VEL) readVal = targetVel;
    else readVal = params[pIdx];
  end

  // Byte collector: nine bytes, value MSB first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byteIdx  <= 4'h0;
      rxSum    <= 8'h00;
      sumCheck <= 8'h00;
      req      <= '0;
    end else if (phase == ST_COLLECT && rxValid) begin
      req <= {req[63:0], rxData};
      if (byteIdx == `LAST_BYTE_IDX) begin
        byteIdx  <= 4'h0;
        sumCheck <= rxSum;
        rxSum    <= 8'h00;
      end else begin
        byteIdx <= byteIdx + 4'h1;
        rxSum   <= rxSum + rxData;
      end
    end
  end

  // Phase sequencer; one request outstanding at a time
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase <= ST_COLLECT;
    end else begin
      case (phase)
        ST_COLLECT: if (rxValid && byteIdx == `LAST_BYTE_IDX) phase <= ST_EXEC;
        ST_EXEC:    phase <= (req.addr == `MODULE_ADDR) ? ST_REPLY : ST_COLLECT;
        ST_REPLY:   phase <= ST_WAIT;
        ST_WAIT:    if (!serBusy && !repStart) phase <= ST_COLLECT;
        default:    phase <= ST_COLLECT;
      endcase
    end
  end

  // Command execution and reply building
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode        <= MODE_VEL;
      targetVel   <= 32'sh0;
      targetPos   <= 32'sh0;
      accumulator <= 32'sh0;
      rep         <= '0;
      repStart    <= 1'b0;
      for (int i = 0; i < `AP_COUNT; i++) params[i] <= 32'sh0;
    end else begin
      repStart <= (phase == ST_REPLY);
      if (phase == ST_EXEC && req.addr == `MODULE_ADDR) begin
        rep.cmd    <= req.cmd;
        rep.value  <= 32'h0;
        rep.status <= `ST_OK;
        if (req.sum != sumCheck) begin
          rep.status <= `ST_BAD_SUM;
        end else begin
          case (req.cmd)
            `CMD_ROT_POS: begin
              mode      <= MODE_VEL;
              targetVel <= req.value;
            end
            `CMD_ROT_NEG: begin
              mode      <= MODE_VEL;
              targetVel <= -req.value;
            end
            `CMD_STOP: begin
              mode      <= MODE_VEL;
              targetVel <= 32'sh0;
            end
            `CMD_MOVE: begin
              if (req.kind == `MOVE_ABS) begin
                mode      <= MODE_POS;
                targetPos <= req.value;
              end else if (req.kind == `MOVE_REL) begin
                mode      <= MODE_POS;
                targetPos <= actualPos + req.value;
              end else begin
                rep.status <= `ST_BAD_TYPE;
              end
            end
            `CMD_PARAM_WR: begin
              if (!pValid) rep.status <= `ST_BAD_TYPE;
              else if (req.kind == `AP_ACTUAL_POS) rep.status <= `ST_NOT_AVAIL;
              else if (req.kind == `AP_TARGET_POS) targetPos <= req.value;
              else if (req.kind == `AP_TARGET_VEL) targetVel <= req.value;
              else params[pIdx] <= req.value;
            end
            `CMD_PARAM_RD: begin
              if (!pValid) rep.status <= `ST_BAD_TYPE;
              else begin
                rep.value <= readVal;
                // Accumulator takes the same value the reply carries
                if (standaloneMode) accumulator <= readVal;
              end
            end
            default: rep.status <= `ST_BAD_CMD;
          endcase
        end
      end
    end
  end

  // Direction of positioning travel
  always_ff @(posedge clk) begin
    if (sys_rst) moveDirNeg <= 1'b0;
    else moveDirNeg <= posDiff[31];
  end

  // Reply busy flag
  always_ff @(posedge clk) begin
    if (sys_rst) replyBusy <= 1'b0;
    else replyBusy <= (phase != ST_COLLECT);
  end

  reply_serializer u_ser (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (repStart),
    .rep     (rep),
    .txValid (txValid),
    .txData  (txData),
    .busy    (serBusy)
  );

  // Assertions
  sequence s_stopExec;
    phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum == sumCheck && req.cmd == `CMD_STOP;
  endsequence
  property p_stop;
    @(posedge clk) disable iff (sys_rst) s_stopExec |=> (mode == MODE_VEL && targetVel == 0);
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not zero velocity");
  property p_rotPos;
    @(posedge clk) disable iff (sys_rst)
      (phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum == sumCheck && req.cmd == `CMD_ROT_POS)
      |=> (mode == MODE_VEL && targetVel == $past(req.value));
  endproperty
  a_rotPos: assert property (p_rotPos) else $error("rotate positive wrong");
  property p_rotNeg;
    @(posedge clk) disable iff (sys_rst)
      (phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum == sumCheck && req.cmd == `CMD_ROT_NEG)
      |=> (mode == MODE_VEL && targetVel == -$past(req.value));
  endproperty
  a_rotNeg: assert property (p_rotNeg) else $error("rotate negative wrong");
  property p_moveRel;
    @(posedge clk) disable iff (sys_rst)
      (phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum == sumCheck && req.cmd == `CMD_MOVE
       && req.kind == `MOVE_REL) |=> (mode == MODE_POS && targetPos == $past(actualPos) + $past(req.value));
  endproperty
  a_moveRel: assert property (p_moveRel) else $error("relative move target wrong");
  property p_badSum;
    @(posedge clk) disable iff (sys_rst)
      (phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum != sumCheck) |=> rep.status == `ST_BAD_SUM;
  endproperty
  a_badSum: assert property (p_badSum) else $error("bad checksum not reported");
  property p_replyStart;
    @(posedge clk) disable iff (sys_rst) (phase == ST_EXEC && req.addr == `MODULE_ADDR) |-> ##2 repStart;
  endproperty
  a_replyStart: assert property (p_replyStart) else $error("reply not started");
  sequence s_firstByte;
    txValid && txData == `REPLY_ADDR;
  endsequence
  property p_replyFrame;
    @(posedge clk) disable iff (sys_rst) $rose(repStart) |-> ##2 s_firstByte ##1 (txValid && txData == `MODULE_ADDR);
  endproperty
  a_replyFrame: assert property (p_replyFrame) else $error("reply header wrong");
  property p_dir;
    @(posedge clk) disable iff (sys_rst) ##1 (moveDirNeg == ($past(targetPos) - $past(actualPos) < 0));
  endproperty
  a_dir: assert property (p_dir) else $error("direction mismatch");
  property p_acc;
    @(posedge clk) disable iff (sys_rst) !standaloneMode |=> $stable(accumulator);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator changed in direct mode");
  property p_accLoad;
    @(posedge clk) disable iff (sys_rst)
      (phase == ST_EXEC && req.addr == `MODULE_ADDR && req.sum == sumCheck && req.cmd == `CMD_PARAM_RD
       && pValid && standaloneMode) |=> accumulator == rep.value;
  endproperty
  a_accLoad: assert property (p_accLoad) else $error("accumulator not loaded in standalone mode");
endmodule
`default_nettype wire

/* motion_cmd_cfg.svh */
`ifndef MOTION_CMD_CFG_SVH
`define MOTION_CMD_CFG_SVH
// Frame geometry
`define FRAME_BYTES      4'd9
`define LAST_BYTE_IDX    4'd8
// Command numbers
`define CMD_ROT_POS      8'h01
`define CMD_ROT_NEG      8'h02
`define CMD_STOP         8'h03
`define CMD_MOVE         8'h04
`define CMD_PARAM_WR     8'h05
`define CMD_PARAM_RD     8'h06
// Move types
`define MOVE_ABS         8'h00
`define MOVE_REL         8'h01
// Status codes
`define ST_OK            8'h64
`define ST_BAD_SUM       8'h01
`define ST_BAD_CMD       8'h02
`define ST_BAD_TYPE      8'h03
`define ST_BAD_VALUE     8'h04
`define ST_NOT_AVAIL     8'h06
// Axis parameter numbers
`define AP_TARGET_POS    8'h00
`define AP_ACTUAL_POS    8'h01
`define AP_TARGET_VEL    8'h02
`define AP_COUNT         16
`define AP_IDX_W         4
// Addresses (arbitrary defaults)
`define MODULE_ADDR      8'h01
`define REPLY_ADDR       8'h02
`endif

/* motion_cmd_pkg.sv */
package motion_cmd_pkg;
  // Decoded request fields
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  cmd;
    logic [7:0]  kind;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  sum;
  } request_t;
  // Reply contents before serialising
  typedef struct packed {
    logic [7:0]  status;
    logic [7:0]  cmd;
    logic [31:0] value;
  } reply_t;
  // Motion mode
  typedef enum logic [0:0] {
    MODE_VEL = 1'b0,
    MODE_POS = 1'b1
  } motion_mode_t;
endpackage

/* reply_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_cfg.svh"
module reply_serializer (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  start,
  input  wire motion_cmd_pkg::reply_t rep,
  output var  logic                  txValid,
  output var  logic [7:0]            txData,
  output var  logic                  busy
);
  import motion_cmd_pkg::*;
  logic [3:0]  idx;      // Byte index being sent
  logic [71:0] frame;    // Bytes 0..8, byte 0 in top lane
  logic [7:0]  runSum;   // Running checksum

  // Emit nine bytes, one per cycle, checksum last
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy    <= 1'b0;
      txValid <= 1'b0;
      txData  <= 8'h00;
      idx     <= 4'h0;
      frame   <= '0;
      runSum  <= 8'h00;
    end else if (start && !busy) begin
      busy   <= 1'b1;
      idx    <= 4'h0;
      runSum <= 8'h00;
      frame  <= {`REPLY_ADDR, `MODULE_ADDR, rep.status, rep.cmd, rep.value, 8'h00};
      txValid <= 1'b0;
    end else if (busy) begin
      txValid <= 1'b1;
      if (idx == `LAST_BYTE_IDX) begin
        txData <= runSum;
        busy   <= 1'b0;
      end else begin
        txData <= frame[71:64];
        runSum <= runSum + frame[71:64];
        frame  <= {frame[63:0], 8'h00};
        idx    <= idx + 4'h1;
      end
    end else begin
      txValid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* motion_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_cfg.svh"
module motion_host_model (
  input  wire logic       clk,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  input  wire logic       replyBusy,
  output var  logic       rxValid,
  output var  logic [7:0] rxData
);
  // Idle bus at time zero
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
  end
  // One framed request, then collect the reply; late flags a hang
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] kind, input logic [31:0] val,
                      input logic [7:0] sumAdj, output logic [7:0] rep [9], output logic late);
    logic [7:0] req [9];
    int         n;
    req = '{`MODULE_ADDR, cmd, kind, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) req[8] += req[i];
    req[8] += sumAdj;
    rep = '{default: 8'h00};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      #2 rxValid = 1'b1;
      rxData = req[i];
    end
    @(posedge clk);
    #2 rxValid = 1'b0;
    // Released line shows no stale byte
    rxData = ~rxData;
    n = 0;
    late = 1'b1;
    // Bounded wait for the reply, then for the end of busy
    for (int c = 0; c < 40 && n < 9; c++) begin
      @(posedge clk);
      if (txValid === 1'b1) begin
        rep[n] = txData;
        n++;
      end
    end
    for (int c = 0; c < 10 && n == 9; c++) begin
      @(posedge clk);
      if (replyBusy === 1'b0) begin
        late = 1'b0;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

/* motion_command_interpreter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "motion_cmd_cfg.svh"
module motion_command_interpreter_tb;
  import motion_cmd_pkg::*;
  logic               clk;
  logic               sysRst;
  logic               rxValid;
  logic [7:0]         rxData;
  logic               standaloneMode;
  logic signed [31:0] actualPos;
  logic               txValid;
  logic [7:0]         txData;
  logic               replyBusy;
  motion_mode_t       mode;
  logic signed [31:0] targetVel;
  logic signed [31:0] targetPos;
  logic               moveDirNeg;
  logic signed [31:0] accumulator;
  int                 errorCnt;
  int                 nChecks;
  logic [31:0]        rv;
  motion_command_interpreter u_motion_command_interpreter (.clk(clk), .sys_rst(sysRst), .rxValid(rxValid),
    .rxData(rxData), .standaloneMode(standaloneMode), .actualPos(actualPos), .txValid(txValid),
    .txData(txData), .replyBusy(replyBusy), .mode(mode), .targetVel(targetVel), .targetPos(targetPos),
    .moveDirNeg(moveDirNeg), .accumulator(accumulator));
  motion_host_model u_motion_host_model (.clk(clk), .txValid(txValid), .txData(txData),
    .replyBusy(replyBusy), .rxValid(rxValid), .rxData(rxData));
  // 50 ns clock
  always #25 clk = ~clk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, stop
  task automatic endOfTest();
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One request with reply framing checks; value field returned in rv
  task automatic request(input logic [7:0] cmd, input logic [7:0] kind, input logic [31:0] val,
                         input logic [7:0] adj, input logic [7:0] st);
    logic [7:0] rep [9];
    logic       late;
    logic [7:0] s;
    u_motion_host_model.xfer(cmd, kind, val, adj, rep, late);
    if (late) begin
      errorCnt++;
      endOfTest();
    end
    s = 8'h00;
    for (int i = 0; i < 8; i++) s += rep[i];
    check(rep[0], `REPLY_ADDR);
    check(rep[1], `MODULE_ADDR);
    check(rep[2], st);
    check(rep[3], cmd);
    check(rep[8], s);
    rv = {rep[4], rep[5], rep[6], rep[7]};
  endtask
  // Both rotate directions
  task automatic scRotate();
    request(`CMD_ROT_POS, 8'h00, 32'h0000_01f4, 8'h00, `ST_OK);
    check({31'h0, mode}, {31'h0, MODE_VEL});
    check(targetVel, 32'h0000_01f4);
    request(`CMD_ROT_NEG, 8'h00, 32'h0000_01f4, 8'h00, `ST_OK);
    check(targetVel, 32'hffff_fe0c);
  endtask
  // Absolute, relative and wrapping moves, then stop in mid-move
  task automatic scMove();
    #2 actualPos = 32'sh0000_2710;
    request(`CMD_MOVE, `MOVE_ABS, 32'h0001_5f90, 8'h00, `ST_OK);
    check({31'h0, mode}, {31'h0, MODE_POS});
    check(targetPos, 32'h0001_5f90);
    check(moveDirNeg, 1'b0);
    request(`CMD_MOVE, `MOVE_REL, 32'hffff_d8f0, 8'h00, `ST_OK);
    check(targetPos, 32'h0000_0000);
    check(moveDirNeg, 1'b1);
    #2 actualPos = 32'shffff_fffe;
    request(`CMD_MOVE, `MOVE_ABS, 32'h7fff_ffff, 8'h00, `ST_OK);
    check(moveDirNeg, 1'b1);
    request(`CMD_STOP, 8'h00, 32'h0000_0000, 8'h00, `ST_OK);
    check({31'h0, mode}, {31'h0, MODE_VEL});
    check(targetVel, 32'h0000_0000);
  endtask
  // Parameter write and read, direct then standalone
  task automatic scParams();
    request(`CMD_PARAM_WR, 8'h04, 32'h0000_c800, 8'h00, `ST_OK);
    request(`CMD_PARAM_RD, 8'h04, 32'h0000_0000, 8'h00, `ST_OK);
    check(rv, 32'h0000_c800);
    check(accumulator, 32'h0000_0000);
    #2 standaloneMode = 1'b1;
    request(`CMD_PARAM_RD, 8'h04, 32'h0000_0000, 8'h00, `ST_OK);
    check(accumulator, 32'h0000_c800);
    // Mid-run reset loses the stored value
    @(posedge clk);
    #2 sysRst = 1'b1;
    repeat (2) @(posedge clk);
    #2 sysRst = 1'b0;
    request(`CMD_PARAM_RD, 8'h04, 32'h0000_0000, 8'h00, `ST_OK);
    check(rv, 32'h0000_0000);
    // Standalone read of the live position also loads the accumulator
    request(`CMD_PARAM_RD, `AP_ACTUAL_POS, 32'h0000_0000, 8'h00, `ST_OK);
    check(rv, 32'hffff_fffe);
    check(accumulator, 32'hffff_fffe);
  endtask
  // Refusals with their status codes
  task automatic scErrors();
    logic [7:0] tc [5] = '{`CMD_ROT_POS, 8'h09, `CMD_PARAM_WR, `CMD_MOVE, `CMD_PARAM_WR};
    logic [7:0] tk [5] = '{8'h00, 8'h00, 8'h10, 8'h02, `AP_ACTUAL_POS};
    logic [7:0] ta [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ts [5] = '{`ST_BAD_SUM, `ST_BAD_CMD, `ST_BAD_TYPE, `ST_BAD_TYPE, `ST_NOT_AVAIL};
    for (int i = 0; i < 5; i++) request(tc[i], tk[i], 32'h0000_0007, ta[i], ts[i]);
    check(targetVel, 32'h0000_0000);
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    sysRst = 1'b1;
    standaloneMode = 1'b0;
    actualPos = 32'sh0;
    errorCnt = 0;
    nChecks = 0;
    repeat (12) @(posedge clk);
    #2 sysRst = 1'b0;
    scRotate();
    scMove();
    scErrors();
    scParams();
    endOfTest();
  end
endmodule
`default_nettype wire
